// [pkg/ldr_cfg.svh]
// Sizes and timing counts shared by both ends of the LUT dual-port RAM
`ifndef LDR_CFG_SVH
`define LDR_CFG_SVH

// ==========================================================================
// Array geometry
`define LDR_ADDR_W          4
`define LDR_DEPTH           16
`define LDR_DATA_W          2

// ==========================================================================
// Timing
`define LDR_CLK_HZ          10000000
`define LDR_WCLK_HIGH_MS    1
// Longest high phase of the write clock, rounded down to whole cycles
`define LDR_WCLK_HIGH_CYC   ((`LDR_WCLK_HIGH_MS * `LDR_CLK_HZ) / 1000)
`define LDR_WCLK_CNT_W      14

`endif

// [pkg/ldr_pkg.sv]
// Types shared by both ends of the LUT dual-port RAM
`include "ldr_cfg.svh"

package ldr_pkg;

    // ======================================================================
    // Write timing and port arrangement
    typedef enum logic [1:0] {
        LDR_MODE_DUAL     = 2'h0,
        LDR_MODE_SP_EDGE  = 2'h1,
        LDR_MODE_SP_LEVEL = 2'h3
    } ldr_mode_t;

    // ======================================================================
    // Write sequencer states, Gray along the path
    typedef enum logic [1:0] {
        LDR_ST_IDLE   = 2'h0,
        LDR_ST_SETUP  = 2'h1,
        LDR_ST_STROBE = 2'h3,
        LDR_ST_HOLD   = 2'h2
    } ldr_state_t;

    typedef logic [`LDR_ADDR_W-1:0] ldr_addr_t;
    typedef logic [`LDR_DATA_W-1:0] ldr_data_t;

endpackage : ldr_pkg

// [pkg/ldr_if.sv]
// Signals between the RAM cell and the logic that drives it
interface ldr_if;
    import ldr_pkg::*;

    ldr_mode_t mode;
    ldr_addr_t addr;
    ldr_addr_t second_read_address;
    ldr_data_t din;
    logic      we;
    logic      wclk;
    logic      primary_read_out;
    logic      second_read_out;

    modport dev (
        input  mode,
        input  addr,
        input  second_read_address,
        input  din,
        input  we,
        input  wclk,
        output primary_read_out,
        output second_read_out
    );

    modport usr (
        output mode,
        output addr,
        output second_read_address,
        output din,
        output we,
        output wclk,
        input  primary_read_out,
        input  second_read_out
    );

endinterface : ldr_if

// [logic/ldr_ram_dev.sv]
// RAM cell end: two 16x1 lookup-table arrays with edge or level write timing
`include "ldr_cfg.svh"
// Operation
// R1 - Dual mode: shared address writes both arrays
// R2 - Primary reads shared address, second reads own
// R3 - Write clock high phase under one millisecond
// R4 - Level mode stores data while strobe high
// R5 - Level mode is transparent like a latch
// R6 - Address stable around the whole strobe
// R7 - Data stable around strobe falling edge
// R8 - Strobe from double clock, ends before edge
// R9 - Edge timing preferred, level only legacy
// R10 - Edge write on clock edge, enable qualifies
// R11 - Dual-port arrangement always edge-triggered
// R12 - Same-cycle read and write, any addresses
// R13 - One timing mode for both generators
// R14 - Reads are combinational, no read clock
// R15 - Contents have no reset value
module ldr_ram_dev #(
    parameter int unsigned WCLK_HIGH_MAX_CYC = `LDR_WCLK_HIGH_CYC
) (
    input  wire logic clk,
    input  wire logic rst_n,
    ldr_if.dev        bus,
    output logic      wr_pulse,
    output logic      same_addr_pulse,
    output logic      wclk_overlong,
    output logic      strobe_addr_err,
    output logic      strobe_data_err
);
    import ldr_pkg::*;

    localparam logic [`LDR_WCLK_CNT_W-1:0] HIGH_MAX =
        `LDR_WCLK_CNT_W'(WCLK_HIGH_MAX_CYC);

    // ======================================================================
    // Decoding
    function automatic logic is_level(
        input ldr_mode_t m
    );
        return (m == LDR_MODE_SP_LEVEL);
    endfunction : is_level

    function automatic logic is_dual(
        input ldr_mode_t m
    );
        return (m == LDR_MODE_DUAL);
    endfunction : is_dual

    // Stored bit, or the incoming bit while a level write is open on it
    function automatic logic lut_read(
        input logic [`LDR_DEPTH-1:0] cells,
        input ldr_addr_t             rd_a,
        input logic                  open_wr,
        input ldr_addr_t             wr_a,
        input logic                  wr_d
    );
        logic hit;
        hit = open_wr && (rd_a == wr_a);
        return hit ? wr_d : cells[rd_a];
    endfunction : lut_read

    // ======================================================================
    // Write control
    logic                  level_mode;
    logic                  dual_mode;
    logic                  wclk_prev_ff;
    logic                  wclk_rise;
    logic                  edge_wr;
    logic                  level_wr;
    logic                  wr_en;
    ldr_data_t             wdata;
    ldr_addr_t             rd_addr [`LDR_DATA_W];
    logic [`LDR_DATA_W-1:0] rd_bit;

    // Only the single-port level setting is level-sensitive
    assign level_mode = is_level(bus.mode);                          // R11 R13 R9
    assign dual_mode  = is_dual(bus.mode);
    assign wclk_rise  = bus.wclk & ~wclk_prev_ff;
    assign edge_wr    = ~level_mode & bus.we & wclk_rise;            // R10
    assign level_wr   = level_mode & bus.we;                         // R4
    assign wr_en      = edge_wr | level_wr;

    // In dual mode both copies take the same bit
    assign wdata = dual_mode ? {`LDR_DATA_W{bus.din[0]}} : bus.din;  // R1

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wclk_prev_ff <= 1'b0;
        end else begin
            wclk_prev_ff <= bus.wclk;
        end
    end

    // ======================================================================
    // Storage, one array per function generator
    // No reset on purpose: the cells power up undefined and stay so until written
    logic [`LDR_DEPTH-1:0] mem_ff [`LDR_DATA_W];

    genvar gi;
    generate
        for (gi = 0; gi < `LDR_DATA_W; gi++) begin : g_lut
            always_ff @(posedge clk) begin
                if (wr_en) begin
                    mem_ff[gi][bus.addr] <= wdata[gi];               // R1 R15 R12
                end
            end

            // Second generator reads its own address only in dual mode
            if (gi == 1) begin : g_sec
                assign rd_addr[gi] = dual_mode ? bus.second_read_address
                                               : bus.addr;            // R2
            end else begin : g_pri
                assign rd_addr[gi] = bus.addr;                       // R2
            end

            assign rd_bit[gi] = lut_read(mem_ff[gi], rd_addr[gi], level_wr,
                                         bus.addr, wdata[gi]);       // R5 R14
        end
    endgenerate

    // ======================================================================
    // Read ports
    // Edge writes: reads see the old word until the write edge, the new one right after; level writes show through while the strobe is high
    assign bus.primary_read_out = rd_bit[0];                         // R14 R2
    assign bus.second_read_out  = rd_bit[1];                         // R14 R2

    // ======================================================================
    // Write and collision pulses
    logic wr_pulse_ff;
    logic same_addr_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_pulse_ff <= 1'b0;
        end else begin
            wr_pulse_ff <= wr_en;
        end
    end

    // In dual mode a second-port read of the word being written in the same cycle is legal, only reported
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            same_addr_ff <= 1'b0;
        end else begin
            same_addr_ff <= edge_wr & dual_mode &
                            (bus.addr == bus.second_read_address);   // R12
        end
    end

    assign wr_pulse        = wr_pulse_ff;
    assign same_addr_pulse = same_addr_ff;

    // ======================================================================
    // Write clock high-phase watch
    // A stalled high phase burns current in the real cell; flag it, cannot stop it
    logic [`LDR_WCLK_CNT_W-1:0] hi_cnt_ff;
    logic [`LDR_WCLK_CNT_W-1:0] nxt_hi_cnt;
    logic                       overlong_ff;

    always_comb begin
        nxt_hi_cnt = '0;
        if (bus.wclk && !level_mode) begin
            if (hi_cnt_ff == HIGH_MAX) begin
                nxt_hi_cnt = hi_cnt_ff;
            end else begin
                nxt_hi_cnt = hi_cnt_ff + `LDR_WCLK_CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_cnt_ff <= '0;
        end else begin
            hi_cnt_ff <= nxt_hi_cnt;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            overlong_ff <= 1'b0;
        end else begin
            overlong_ff <= (nxt_hi_cnt == HIGH_MAX);                 // R3
        end
    end

    assign wclk_overlong = overlong_ff;

    // ======================================================================
    // Level strobe discipline watch
    logic      we_prev_ff;
    ldr_addr_t addr_prev_ff;
    ldr_data_t din_prev_ff;
    logic      addr_err_ff;
    logic      data_err_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            we_prev_ff   <= 1'b0;
            addr_prev_ff <= '0;
            din_prev_ff  <= '0;
        end else begin
            we_prev_ff   <= bus.we;
            addr_prev_ff <= bus.addr;
            din_prev_ff  <= bus.din;
        end
    end

    // An address move under an open strobe spoils the new word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_err_ff <= 1'b0;
        end else begin
            addr_err_ff <= level_mode & bus.we & we_prev_ff &
                           (bus.addr != addr_prev_ff);               // R6
        end
    end

    // Data moving as the strobe falls leaves the word uncertain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_err_ff <= 1'b0;
        end else begin
            data_err_ff <= level_mode & we_prev_ff & ~bus.we &
                           (bus.din != din_prev_ff);                 // R7
        end
    end

    assign strobe_addr_err = addr_err_ff;
    assign strobe_data_err = data_err_ff;

endmodule : ldr_ram_dev

// [logic/ldr_ram_usr.sv]
// Driving-logic end: sequences writes and read addresses into the RAM cell
module ldr_ram_usr (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  ldr_pkg::ldr_mode_t cfg_mode,
    input  wire logic         wr_req,
    input  ldr_pkg::ldr_addr_t wr_addr,
    input  ldr_pkg::ldr_data_t wr_data,
    output logic              wr_ready,
    input  ldr_pkg::ldr_addr_t rd_addr,
    output logic              rd_primary_data,
    output logic              rd_second_data,
    ldr_if.usr                bus
);
    import ldr_pkg::*;

    // ======================================================================
    // Write sequencer
    ldr_state_t state_ff;
    ldr_state_t nxt_state;
    ldr_mode_t  mode_ff;
    ldr_mode_t  nxt_mode;
    ldr_addr_t  addr_ff;
    ldr_data_t  data_ff;
    logic       we_ff;
    logic       wclk_ff;
    logic       level;

    // Strobe shape follows the mode taken at the accept edge, not the last one
    assign nxt_mode = (state_ff == LDR_ST_IDLE) ? cfg_mode : mode_ff;
    assign level    = (nxt_mode == LDR_MODE_SP_LEVEL);                // R13
    assign wr_ready = (state_ff == LDR_ST_IDLE);

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            LDR_ST_IDLE: begin
                if (wr_req) begin
                    nxt_state = LDR_ST_SETUP;
                end
            end
            LDR_ST_SETUP: begin
                nxt_state = LDR_ST_STROBE;                           // R6
            end
            LDR_ST_STROBE: begin
                nxt_state = LDR_ST_HOLD;                             // R3 R8
            end
            LDR_ST_HOLD: begin
                nxt_state = LDR_ST_IDLE;                             // R7
            end
            default: begin
                nxt_state = LDR_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= LDR_ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Mode changes only between writes so both arrays share one timing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_ff <= LDR_MODE_DUAL;                                // R9
        end else if (state_ff == LDR_ST_IDLE) begin
            mode_ff <= cfg_mode;
        end
    end

    // Address and data frozen from setup until the sequence ends
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            addr_ff <= '0;
            data_ff <= '0;
        end else if (state_ff == LDR_ST_IDLE) begin
            addr_ff <= wr_addr;                                      // R6
            data_ff <= wr_data;                                      // R7
        end
    end

    // Edge mode: enable from setup, one-cycle clock pulse in strobe.
    // Level mode: strobe is a single registered cycle, so it always drops
    // at the next rising edge.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            we_ff   <= 1'b0;
            wclk_ff <= 1'b0;
        end else begin
            we_ff   <= (nxt_state == LDR_ST_STROBE) |
                       ((nxt_state == LDR_ST_SETUP) & ~level);       // R8
            wclk_ff <= (nxt_state == LDR_ST_STROBE) & ~level;        // R3
        end
    end

    // ======================================================================
    // Read side
    ldr_addr_t sra_ff;
    logic      pri_ff;
    logic      sec_ff;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sra_ff <= '0;
            pri_ff <= 1'b0;
            sec_ff <= 1'b0;
        end else begin
            sra_ff <= rd_addr;
            pri_ff <= bus.primary_read_out;
            sec_ff <= bus.second_read_out;
        end
    end

    assign rd_primary_data         = pri_ff;
    assign rd_second_data          = sec_ff;
    assign bus.mode                = mode_ff;
    assign bus.addr                = addr_ff;
    assign bus.din                 = data_ff;
    assign bus.we                  = we_ff;
    assign bus.wclk                = wclk_ff;
    assign bus.second_read_address = sra_ff;

endmodule : ldr_ram_usr

// [tb/ldr_ram_props.sv]
// Concurrent checks on the signals between the two RAM ends
module ldr_ram_props (
    input wire logic          clk,
    input wire logic          rst_n,
    input ldr_pkg::ldr_mode_t mode,
    input ldr_pkg::ldr_addr_t addr,
    input ldr_pkg::ldr_addr_t second_read_address,
    input ldr_pkg::ldr_data_t din,
    input wire logic          we,
    input wire logic          wclk,
    input wire logic          primary_read_out,
    input wire logic          second_read_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import ldr_pkg::*;

    // ==================================================================
    // Helper
    // Last cycle's data, so a write can be compared after its edge
    ldr_data_t din_ff;
    always_ff @(posedge clk) begin
        din_ff <= din;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ==================================================================
    // Edge timing
    wclk_pulse_short_a: assert property ($rose(wclk) |=> !wclk)
        else $error("write clock held high past one cycle");
    edge_enable_a: assert property ($rose(wclk) |-> we && mode != LDR_MODE_SP_LEVEL)
        else $error("write clock edge without enable or in level mode");
    primary_write_a: assert property ($rose(wclk) |=> primary_read_out == din_ff[0])
        else $error("primary output misses written bit");
    second_dual_a: assert property ($rose(wclk) && mode == LDR_MODE_DUAL
        |=> second_read_address != addr || second_read_out == din_ff[0])
        else $error("second output misses written bit");
    second_edge_a: assert property ($rose(wclk) && mode == LDR_MODE_SP_EDGE
        |=> second_read_out == din_ff[1])
        else $error("second array misses written bit");

    // ==================================================================
    // Level timing
    level_transparent_a: assert property (mode == LDR_MODE_SP_LEVEL && we
        |-> primary_read_out == din[0] && second_read_out == din[1])
        else $error("level write not transparent");
    level_store_a: assert property (mode == LDR_MODE_SP_LEVEL && $fell(we)
        |-> primary_read_out == din_ff[0] && second_read_out == din_ff[1])
        else $error("level write not stored");
    level_addr_a: assert property (mode == LDR_MODE_SP_LEVEL && we
        |-> $stable(addr) ##1 !we)
        else $error("address moved under strobe or strobe too long");
    level_data_a: assert property (mode == LDR_MODE_SP_LEVEL && $fell(we) |-> $stable(din))
        else $error("data moved at strobe fall");
endmodule : ldr_ram_props

// [tb/test_lut_dual_port_ram.sv]
// Self-checking bench for both ends of the LUT dual-port RAM
module test_lut_dual_port_ram;
    timeunit 1ns;
    timeprecision 1ns;
    import ldr_pkg::*;

    // Short overlong limit keeps the fault run brief
    localparam int FAST_CYC = 8;
    logic      clk         = 1'b0;
    logic      rst_n       = 1'b0;
    ldr_mode_t cfg_mode    = LDR_MODE_DUAL;
    logic      wr_req      = 1'b0;
    ldr_addr_t wr_addr     = 4'h0;
    ldr_data_t wr_data     = 2'h0;
    ldr_addr_t rd_addr     = 4'h0;
    logic      wr_ready;
    logic      rd_primary_data;
    logic      rd_second_data;
    logic      f_over;
    logic      f_aerr;
    logic      f_derr;
    logic      m_pulse;
    logic      m_same;
    logic      m_over;
    logic      m_aerr;
    logic      m_derr;
    logic      m_bad       = 1'b0;
    int        err_count   = 0;
    int        checks_done = 0;
    int        m0 [16];
    int        m1 [16];

    ldr_if bus ();
    ldr_if bus_f ();
    always #50 clk = ~clk;

    ldr_ram_usr u_ldr_ram_usr (.clk(clk), .rst_n(rst_n), .cfg_mode(cfg_mode), .wr_req(wr_req),
        .wr_addr(wr_addr), .wr_data(wr_data), .wr_ready(wr_ready), .rd_addr(rd_addr),
        .rd_primary_data(rd_primary_data), .rd_second_data(rd_second_data), .bus(bus.usr));
    ldr_ram_dev u_ldr_ram_dev (.clk(clk), .rst_n(rst_n), .bus(bus.dev), .wr_pulse(m_pulse),
        .same_addr_pulse(m_same), .wclk_overlong(m_over), .strobe_addr_err(m_aerr),
        .strobe_data_err(m_derr));

    // Legal driving must never raise a fault flag on the main cell
    always @(posedge clk) begin
        if (rst_n) begin
            m_bad <= m_bad | m_over | m_aerr | m_derr;
        end
    end
    // Second cell driven straight by the bench to break the driving rules
    ldr_ram_dev #(.WCLK_HIGH_MAX_CYC(FAST_CYC)) u_ldr_ram_dev_f (.clk(clk), .rst_n(rst_n),
        .bus(bus_f.dev), .wr_pulse(), .same_addr_pulse(), .wclk_overlong(f_over),
        .strobe_addr_err(f_aerr), .strobe_data_err(f_derr));
    ldr_ram_props u_ldr_ram_props (.clk(clk), .rst_n(rst_n), .mode(bus.mode), .addr(bus.addr),
        .second_read_address(bus.second_read_address), .din(bus.din), .we(bus.we),
        .wclk(bus.wclk), .primary_read_out(bus.primary_read_out),
        .second_read_out(bus.second_read_out));

    // ==================================================================
    // Tasks
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : tally_and_finish

    task automatic chk(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %b seen %b", name, exp, got);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic wait_ready();
        int n;
        for (n = 0; n < 20 && wr_ready !== 1'b1; n++) begin
            step(1);
        end
        if (wr_ready !== 1'b1) begin
            err_count++;
            tally_and_finish();
        end
    endtask : wait_ready

    task automatic do_write(input ldr_mode_t m, input int a, input int d);
        wait_ready();
        cfg_mode = m;
        wr_addr = a[3:0];
        wr_data = d[1:0];
        wr_req = 1'b1;
        step(1);
        wr_req = 1'b0;
        chk("wr_pulse", 1'b0, m_pulse);
        step(2);
        chk("wr_pulse", 1'b1, m_pulse);
        chk("same_addr_pulse", (m == LDR_MODE_DUAL) && (a[3:0] == rd_addr), m_same);
        m0[a] = d & 1;
        m1[a] = (m == LDR_MODE_DUAL) ? (d & 1) : ((d >> 1) & 1);
    endtask : do_write

    task automatic do_read(input ldr_mode_t m, input int a, input int r);
        int ep;
        int es;
        wait_ready();
        wr_addr = a[3:0];
        rd_addr = r[3:0];
        step(3);
        ep = m0[a];
        es = (m == LDR_MODE_DUAL) ? m1[r] : m1[a];
        chk("rd_primary_data", ep[0], rd_primary_data);
        chk("rd_second_data", es[0], rd_second_data);
    endtask : do_read

    task automatic fault_run();
        int  n;
        logic sa;
        logic sd;
        bus_f.mode = LDR_MODE_SP_EDGE;
        bus_f.wclk = 1'b1;
        step(4);
        chk("wclk_overlong", 1'b0, f_over);
        step(FAST_CYC + 2);
        chk("wclk_overlong", 1'b1, f_over);
        bus_f.wclk = 1'b0;
        bus_f.mode = LDR_MODE_SP_LEVEL;
        bus_f.we = 1'b1;
        step(1);
        bus_f.addr = 4'h5;
        step(1);
        bus_f.din = 2'h3;
        bus_f.we = 1'b0;
        sa = 1'b0;
        sd = 1'b0;
        for (n = 0; n < 5; n++) begin
            sa = sa | (f_aerr === 1'b1);
            sd = sd | (f_derr === 1'b1);
            step(1);
        end
        chk("strobe_addr_err", 1'b1, sa);
        chk("strobe_data_err", 1'b1, sd);
    endtask : fault_run

    // ==================================================================
    // Main sequence
    initial begin : main_seq
        ldr_mode_t modes [3];
        int        i;
        int        k;
        modes = '{LDR_MODE_DUAL, LDR_MODE_SP_EDGE, LDR_MODE_SP_LEVEL};
        bus_f.mode = LDR_MODE_DUAL;
        bus_f.addr = 4'h0;
        bus_f.second_read_address = 4'h0;
        bus_f.din = 2'h0;
        bus_f.we = 1'b0;
        bus_f.wclk = 1'b0;
        void'($urandom(32'h446d_20d2));
        step(16);
        rst_n = 1'b1;
        for (k = 0; k < 3; k++) begin
            for (i = 0; i < 16; i++) begin
                do_write(modes[k], i, $urandom_range(3, 0));
                do_read(modes[k], i, i);
            end
            for (i = 0; i < 16; i++) begin
                do_read(modes[k], i, 15 - i);
            end
        end
        chk("main_fault_flags", 1'b0, m_bad);
        fault_run();
        tally_and_finish();
    end
endmodule : test_lut_dual_port_ram
